// *** dacr_conv_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module dacr_conv_model (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic trig_i,
   input wire logic [7:0] delay_i,
   output logic done_o,
   output logic [11:0] data_o
);
   int cnt;
   logic [11:0] res;
   // Result shows only with done; inverted otherwise so stale data fails
   always_ff @(posedge clk_i) begin
      done_o <= 1'b0;
      data_o <= ~res;
      if (!resetn_i) begin
         cnt <= 0;
         res <= 12'h05a3;
      end else if (trig_i) begin
         // A new trigger restarts the conversion
         cnt <= int'(delay_i);
      end else if (cnt == 1) begin
         cnt <= 0;
         res <= res + 12'h0137;
         done_o <= 1'b1;
         data_o <= res + 12'h0137;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule
`default_nettype wire

// *** dacr_irq_route.sv ***
`timescale 1ns/10ps
`default_nettype none
module dacr_irq_route
   import dacr_pkg::*;
#(
   parameter int NLINES = 6
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic set_i,
   input wire logic clear_i,
   input wire logic enable_i,
   input wire logic [2:0] sel_i,
   output logic flag_o,
   output logic [NLINES-1:0] lines_o
);
   // Line index 0 is the lowest request line; code 001 drives none
   function automatic logic [NLINES-1:0] line_decode(logic [2:0] s);
      logic [NLINES-1:0] v;
      v = '0;
      if (s == 3'h0 || s == 3'h2)
         v[0] = 1'b1;
      else if (s != 3'h1)
         v[s - 3'h2] = 1'b1;
      return v;
   endfunction

   // Set wins over clear so a completion in the clear cycle is kept
   always_ff @(posedge clk_i) begin
      if (!resetn_i)
         flag_o <= 1'b0;
      else if (set_i)
         flag_o <= 1'b1;
      else if (clear_i)
         flag_o <= 1'b0;
   end

   assign lines_o = (flag_o && enable_i) ? line_decode(sel_i) : '0;

   a_irq_set_wins: assert property (@(posedge clk_i)
      disable iff (!resetn_i) set_i |=> flag_o)
      else $error("completion lost");
   a_irq_clear_works: assert property (@(posedge clk_i)
      disable iff (!resetn_i) clear_i && !set_i |=> !flag_o)
      else $error("flag not cleared");
   a_irq_none_line: assert property (@(posedge clk_i)
      disable iff (!resetn_i) sel_i == 3'h1 |-> lines_o == '0)
      else $error("line driven while none selected");
endmodule
`default_nettype wire

// *** dacr_map.svh ***
`ifndef DACR_MAP_SVH
`define DACR_MAP_SVH
// Byte offsets within the 16-byte port window
`define DACR_OFF_AD_LOW 4'h4
`define DACR_OFF_AD_HIGH 4'h5
`define DACR_OFF_DI_LOW 4'h6
`define DACR_OFF_DI_HIGH 4'h7
`define DACR_OFF_IRQ_CLEAR 4'h8
`define DACR_OFF_GAIN 4'h9
`define DACR_OFF_CHANNEL 4'hA
`define DACR_OFF_MODE 4'hB
`define DACR_OFF_TRIGGER 4'hC
`define DACR_OFF_DO_LOW 4'hD
`define DACR_OFF_DO_HIGH 4'hE
// Field positions
`define DACR_GAIN_MSB 1
`define DACR_CHAN_MSB 3
`define DACR_MODE_MSB 2
`define DACR_IRQSEL_LSB 4
`define DACR_IRQSEL_MSB 6
`define DACR_BUSY_BIT 4
// Reset values
`define DACR_RST_GAIN 2'h0
`define DACR_RST_CHAN 4'h0
`define DACR_RST_MODE 3'h0
`define DACR_RST_IRQSEL 3'h1
`define DACR_RST_DO 16'h0000
`define DACR_RST_BYTE 8'h00
`endif

// *** dacr_pacer.sv ***
`timescale 1ns/10ps
`default_nettype none
module dacr_pacer
   import dacr_pkg::*;
#(
   parameter int CW = 16
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic enable_i,
   input wire logic [CW-1:0] reload_lo_i,
   input wire logic [CW-1:0] reload_hi_i,
   output logic tick_o
);
   dacr_pacer_e state;
   logic [CW-1:0] cnt_lo;
   logic [CW-1:0] cnt_hi;
   wire lo_wrap = (cnt_lo == CW'(1));
   wire hi_wrap = (cnt_hi == CW'(1));
   // Two counters cascaded into one long period; a reload of zero
   // gives the full 2**CW count of that stage
   always_ff @(posedge clk_i) begin
      if (!resetn_i || !enable_i) begin
         state <= DACR_PACER_IDLE;
         cnt_lo <= '0;
         cnt_hi <= '0;
         tick_o <= 1'b0;
      end else begin
         case (state)
            DACR_PACER_IDLE: begin
               state <= DACR_PACER_RUN;
               cnt_lo <= reload_lo_i;
               cnt_hi <= reload_hi_i;
               tick_o <= 1'b0;
            end
            DACR_PACER_RUN: begin
               cnt_lo <= lo_wrap ? reload_lo_i : cnt_lo - CW'(1);
               if (lo_wrap)
                  cnt_hi <= hi_wrap ? reload_hi_i : cnt_hi - CW'(1);
               tick_o <= lo_wrap && hi_wrap;
            end
            default: state <= DACR_PACER_IDLE;
         endcase
      end
   end

   a_pacer_tick_one: assert property (@(posedge clk_i)
      disable iff (!resetn_i) tick_o |=> !tick_o ||
      (reload_lo_i == CW'(1) && reload_hi_i == CW'(1)))
      else $error("pacer tick longer than one cycle");
endmodule
`default_nettype wire

// *** dacr_pkg.sv ***
`default_nettype none
package dacr_pkg;
   // Decoded conversion mode
   typedef struct packed {
      logic sw_trig;
      logic pacer;
      logic poll;
      logic intr;
   } dacr_mode_s;
   // Pacer timer state
   typedef enum logic [0:0] {
      DACR_PACER_IDLE,
      DACR_PACER_RUN
   } dacr_pacer_e;
   typedef logic [7:0] dacr_byte_t;
endpackage
`default_nettype wire

// *** dacr_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dacr_map.svh"
// What this block does
// - Digital inputs 7..0 read at offset 6, 15..8 at offset 7.
// - In interrupt transfer, each finished conversion sets the status flag.
// - Any write at offset 8 clears the flag, except in a completion cycle; next completion raises again.
// - Offset 9 bits 1..0 pick gain code; upper bits ignored.
// - Offset A bits 3..0 pick channel; differential ignores bit 3.
// - Mode bits 2..0 pick trigger source and transfer path.
// - Mode bits 6..4 pick interrupt line; 001 drives none.
// - Pacer mode starts conversions periodically from the pacer timer.
// - A write at offset C gives one trigger pulse in modes 000 and 001 only.
// - Offsets D and E latch and hold the 16 digital outputs.
// - Conversion has a trigger stage and a transfer stage.
// - Busy reads at bit 4 of offset 5 during conversion.
// - Interrupt transfer drives selected request on each completion.
// - Pacer is two 16-bit counters cascaded into one 32-bit timer.
module dacr_top
   import dacr_pkg::*;
#(
   parameter int DW = 16,
   parameter int AW = 12,
   parameter int PW = 16,
   parameter int NIRQ = 6
) (
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   input wire logic [DW-1:0] DI_I,
   output logic [DW-1:0] DO_O,
   input wire logic DIFF_MODE_I,
   output logic [1:0] GAIN_CODE_O,
   output logic [3:0] CHANNEL_O,
   output logic ADC_TRIGGER_O,
   input wire logic ADC_DONE_I,
   input wire logic [AW-1:0] ADC_DATA_I,
   input wire logic [PW-1:0] PACER_RELOAD_LO_I,
   input wire logic [PW-1:0] PACER_RELOAD_HI_I,
   output logic BUSY_O,
   output logic IRQ_FLAG_O,
   output logic [NIRQ-1:0] IRQ_O
);
   logic [1:0] gain_code;
   logic [3:0] chan_code;
   logic [2:0] mode_code;
   logic [2:0] irq_sel;
   logic [DW-1:0] do_latch;
   logic busy;
   logic trig;
   logic [AW-1:0] result;
   logic [7:0] rdata;
   logic pacer_tick;
   logic irq_flag;
   logic [NIRQ-1:0] irq_lines;
   logic [7:0] next_rdata;

   // Mode table; unlisted codes enable nothing
   function automatic dacr_mode_s mode_decode(logic [2:0] m);
      dacr_mode_s d;
      d = '0;
      case (m)
         3'h0, 3'h1: begin
            d.sw_trig = 1'b1;
            d.poll = 1'b1;
         end
         3'h2: d.pacer = 1'b1;
         3'h6: begin
            d.pacer = 1'b1;
            d.poll = 1'b1;
            d.intr = 1'b1;
         end
         default: d = '0;
      endcase
      return d;
   endfunction

   function automatic logic is_write(logic w, logic [3:0] a,
                                      logic [3:0] off);
      return w && (a == off);
   endfunction

   dacr_mode_s mode;
   assign mode = mode_decode(mode_code);

   wire wr_clear = is_write(WR_I, ADDR_I, `DACR_OFF_IRQ_CLEAR);
   wire wr_gain = is_write(WR_I, ADDR_I, `DACR_OFF_GAIN);
   wire wr_chan = is_write(WR_I, ADDR_I, `DACR_OFF_CHANNEL);
   wire wr_mode = is_write(WR_I, ADDR_I, `DACR_OFF_MODE);
   wire wr_trig = is_write(WR_I, ADDR_I, `DACR_OFF_TRIGGER);
   wire wr_do_lo = is_write(WR_I, ADDR_I, `DACR_OFF_DO_LOW);
   wire wr_do_hi = is_write(WR_I, ADDR_I, `DACR_OFF_DO_HIGH);

   // Trigger stage: software strobe or pacer tick
   wire sw_start = wr_trig && mode.sw_trig;
   wire pacer_start = pacer_tick && mode.pacer;
   wire start = sw_start || pacer_start;
   // Transfer stage: completion is only taken while converting
   wire done = ADC_DONE_I && busy;
   wire irq_set = done && mode.intr;

   // Control registers; reads never reach these
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         gain_code <= `DACR_RST_GAIN;
         chan_code <= `DACR_RST_CHAN;
         mode_code <= `DACR_RST_MODE;
         irq_sel <= `DACR_RST_IRQSEL;
      end else begin
         if (wr_gain)
            gain_code <= WDATA_I[`DACR_GAIN_MSB:0];
         if (wr_chan)
            chan_code <= WDATA_I[`DACR_CHAN_MSB:0];
         if (wr_mode) begin
            mode_code <= WDATA_I[`DACR_MODE_MSB:0];
            irq_sel <= WDATA_I[`DACR_IRQSEL_MSB:`DACR_IRQSEL_LSB];
         end
      end
   end

   // Digital outputs hold until rewritten
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I)
         do_latch <= `DACR_RST_DO;
      else if (wr_do_lo)
         do_latch[7:0] <= WDATA_I;
      else if (wr_do_hi)
         do_latch[15:8] <= WDATA_I;
   end

   // A new start wins over a completion in the same cycle
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         busy <= 1'b0;
         trig <= 1'b0;
         result <= '0;
      end else begin
         trig <= start;
         if (start)
            busy <= 1'b1;
         else if (done)
            busy <= 1'b0;
         if (done)
            result <= ADC_DATA_I;
      end
   end

   // Read mux; write-only offsets read as zero
   always_comb begin
      next_rdata = `DACR_RST_BYTE;
      case (ADDR_I)
         `DACR_OFF_AD_LOW: next_rdata = result[7:0];
         `DACR_OFF_AD_HIGH: begin
            next_rdata[3:0] = result[AW-1:8];
            next_rdata[`DACR_BUSY_BIT] = busy;
         end
         `DACR_OFF_DI_LOW: next_rdata = DI_I[7:0];
         `DACR_OFF_DI_HIGH: next_rdata = DI_I[15:8];
         default: next_rdata = `DACR_RST_BYTE;
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I)
         rdata <= `DACR_RST_BYTE;
      else if (RD_I)
         rdata <= next_rdata;
   end

   dacr_pacer #(
      .CW(PW)
   ) u_pacer (
      .clk_i(CLK_I),
      .resetn_i(RESETN_I),
      .enable_i(mode.pacer),
      .reload_lo_i(PACER_RELOAD_LO_I),
      .reload_hi_i(PACER_RELOAD_HI_I),
      .tick_o(pacer_tick)
   );

   dacr_irq_route #(
      .NLINES(NIRQ)
   ) u_irq (
      .clk_i(CLK_I),
      .resetn_i(RESETN_I),
      .set_i(irq_set),
      .clear_i(wr_clear),
      .enable_i(mode.intr),
      .sel_i(irq_sel),
      .flag_o(irq_flag),
      .lines_o(irq_lines)
   );

   assign RDATA_O = rdata;
   assign DO_O = do_latch;
   assign GAIN_CODE_O = gain_code;
   // Differential pairs ignore the top select bit
   assign CHANNEL_O = {chan_code[3] && !DIFF_MODE_I, chan_code[2:0]};
   assign ADC_TRIGGER_O = trig;
   assign BUSY_O = busy;
   assign IRQ_FLAG_O = irq_flag;
   assign IRQ_O = irq_lines;

   sequence s_sw_write;
      wr_trig && mode.sw_trig;
   endsequence
   sequence s_pulse_once;
      ADC_TRIGGER_O ##1 (!ADC_TRIGGER_O || $past(start));
   endsequence

   a_trig_pulse_once: assert property (@(posedge CLK_I)
      disable iff (!RESETN_I) s_sw_write |=> s_pulse_once)
      else $error("software trigger pulse wrong");
   a_busy_on_trigger: assert property (@(posedge CLK_I)
      disable iff (!RESETN_I) ADC_TRIGGER_O |-> BUSY_O)
      else $error("busy missing during conversion");
   a_busy_clears: assert property (@(posedge CLK_I)
      disable iff (!RESETN_I) done && !start |=> !BUSY_O &&
      (RDATA_O == $past(RDATA_O) || $past(RD_I)))
      else $error("busy not cleared at completion");
   a_do_holds: assert property (@(posedge CLK_I)
      disable iff (!RESETN_I) !wr_do_lo && !wr_do_hi |=> DO_O == $past(DO_O))
      else $error("digital outputs changed without write");
   a_do_low_load: assert property (@(posedge CLK_I)
      disable iff (!RESETN_I) wr_do_lo |=> DO_O[7:0] == $past(WDATA_I))
      else $error("low output byte not latched");
   a_di_high_read: assert property (@(posedge CLK_I)
      disable iff (!RESETN_I) RD_I && ADDR_I == `DACR_OFF_DI_HIGH
      |=> RDATA_O == $past(DI_I[15:8]))
      else $error("input high byte wrong");
   a_read_no_effect: assert property (@(posedge CLK_I)
      disable iff (!RESETN_I) RD_I && !WR_I |=> $stable(gain_code) &&
      $stable(mode_code) && $stable(chan_code))
      else $error("read disturbed a setting");
   a_irq_needs_mode: assert property (@(posedge CLK_I)
      disable iff (!RESETN_I) !mode.intr |-> IRQ_O == '0)
      else $error("request driven outside interrupt mode");
   a_pacer_starts: assert property (@(posedge CLK_I)
      disable iff (!RESETN_I) pacer_tick && mode.pacer |=> ADC_TRIGGER_O)
      else $error("pacer tick did not trigger");
   a_gain_load: assert property (@(posedge CLK_I)
      disable iff (!RESETN_I) wr_gain |=> GAIN_CODE_O == $past(WDATA_I[1:0]))
      else $error("gain code not taken");
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dacr_map.svh"
module tb_top;
   logic CLK_I, RESETN_I, WR_I, RD_I, DIFF_MODE_I;
   logic [3:0] ADDR_I;
   logic [7:0] WDATA_I, rv, cdelay;
   logic [15:0] DI_I, plo, phi;
   logic [7:0] RDATA_O;
   logic [15:0] DO_O;
   logic [1:0] GAIN_CODE_O;
   logic [3:0] CHANNEL_O;
   logic ADC_TRIGGER_O, ADC_DONE_I, BUSY_O, IRQ_FLAG_O;
   logic [11:0] ADC_DATA_I;
   logic [5:0] IRQ_O;
   logic [11:0] q[$];
   int n_fail, checks, seed, ntrig, cyc, t1, k, i, exp_do, exp_ch;

   dacr_top u_dut (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .ADDR_I(ADDR_I),
      .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
      .DI_I(DI_I), .DO_O(DO_O), .DIFF_MODE_I(DIFF_MODE_I),
      .GAIN_CODE_O(GAIN_CODE_O), .CHANNEL_O(CHANNEL_O),
      .ADC_TRIGGER_O(ADC_TRIGGER_O), .ADC_DONE_I(ADC_DONE_I),
      .ADC_DATA_I(ADC_DATA_I), .PACER_RELOAD_LO_I(plo),
      .PACER_RELOAD_HI_I(phi), .BUSY_O(BUSY_O), .IRQ_FLAG_O(IRQ_FLAG_O),
      .IRQ_O(IRQ_O));
   dacr_conv_model u_conv (.clk_i(CLK_I), .resetn_i(RESETN_I),
      .trig_i(ADC_TRIGGER_O), .delay_i(cdelay), .done_o(ADC_DONE_I),
      .data_o(ADC_DATA_I));

   always #2.5 CLK_I = ~CLK_I;
   // Mid-cycle sampling keeps clear of the edge that launches the pulses
   always @(negedge CLK_I) begin
      cyc++;
      if (ADC_TRIGGER_O === 1'b1) ntrig++;
      if (ADC_DONE_I === 1'b1) q.push_back(ADC_DATA_I);
   end

   task results;
      if (n_fail == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task hang;
      n_fail++;
      results();
   endtask
   // All tasks start and end 1 ns after a rising edge
   task tick(input int n);
      repeat (n) @(posedge CLK_I);
      #1;
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      ADDR_I = a;
      WDATA_I = d;
      WR_I = 1'b1;
      tick(1);
      WR_I = 1'b0;
      // One idle edge so back-to-back writes never retoggle the strobe
      tick(1);
   endtask
   task rd(input logic [3:0] a, output logic [7:0] d);
      ADDR_I = a;
      RD_I = 1'b1;
      tick(1);
      RD_I = 1'b0;
      tick(1);
      d = RDATA_O;
   endtask
   task wait_sig(input bit trig);
      int w;
      w = 0;
      do begin
         tick(1);
         w++;
      end while ((trig ? ADC_TRIGGER_O : ADC_DONE_I) !== 1'b1 && w < 400);
      if (w >= 400) hang();
      else tick(1);
   endtask
   // Polls busy with a bound, as a presence probe would
   task poll;
      int w;
      w = 0;
      do begin
         rd(`DACR_OFF_AD_HIGH, rv);
         w++;
      end while (rv[4] !== 1'b0 && w < 100);
      if (w >= 100) hang();
   endtask
   function automatic logic [5:0] irq_exp(input int s);
      irq_exp = 6'h00;
      if (s == 0 || s == 2) irq_exp = 6'h01;
      else if (s >= 3) irq_exp = 6'h01 << (s - 2);
   endfunction

   initial begin
      seed = 32'h256a;
      CLK_I = 0;
      RESETN_I = 0;
      {WR_I, RD_I, ADDR_I, WDATA_I, DIFF_MODE_I} = '0;
      DI_I = 16'h0000;
      plo = 16'h0004;
      phi = 16'h0003;
      cdelay = 8'h04;
      {n_fail, checks, ntrig, cyc, exp_do} = '0;
      tick(2);
      RESETN_I = 1;
      chk({RDATA_O, DO_O, GAIN_CODE_O, CHANNEL_O}, 0);
      chk({BUSY_O, IRQ_FLAG_O, IRQ_O, ADC_TRIGGER_O}, 0);
      for (i = 0; i < 4; i++) begin
         DI_I = 16'($random(seed));
         tick(2);
         rd(`DACR_OFF_DI_LOW, rv);
         chk(rv, DI_I[7:0]);
         rd(`DACR_OFF_DI_HIGH, rv);
         chk(rv, DI_I[15:8]);
      end
      for (i = 0; i < 4; i++) begin
         rv = 8'($random(seed));
         wr(`DACR_OFF_GAIN, {rv[7:2], i[1:0]});
         tick(1);
         chk(GAIN_CODE_O, i);
      end
      for (i = 0; i < 8; i++) begin
         rv = 8'($random(seed));
         DIFF_MODE_I = i[0];
         exp_ch = rv[3:0] & (i[0] ? 4'h7 : 4'hf);
         wr(`DACR_OFF_CHANNEL, rv);
         tick(1);
         chk(CHANNEL_O, exp_ch);
      end
      for (i = 0; i < 4; i++) begin
         rv = 8'($random(seed));
         wr(i[0] ? `DACR_OFF_DO_HIGH : `DACR_OFF_DO_LOW, rv);
         if (i[0]) exp_do[15:8] = rv;
         else exp_do[7:0] = rv;
         tick(1);
         chk(DO_O, exp_do);
      end
      // Ignored places must leave outputs, gain and channel alone and start nothing
      k = ntrig;
      wr(4'h0, 8'($random(seed)));
      wr(4'hF, 8'($random(seed)));
      for (i = 0; i < 16; i++) begin
         if (i < 4 || i > 7) begin
            rd(i[3:0], rv);
            chk(rv, 0);
         end
      end
      chk({DO_O, GAIN_CODE_O, CHANNEL_O},
         {exp_do[15:0], 2'h3, exp_ch[3:0]});
      chk(ntrig, k);
      for (i = 0; i < 2; i++) begin
         wr(`DACR_OFF_MODE, {4'h1, 3'h0, i[0]});
         tick(3);
         k = ntrig;
         rv = 8'($random(seed));
         cdelay = 8'h08 + rv[3:0];
         wr(`DACR_OFF_TRIGGER, rv);
         rd(`DACR_OFF_AD_HIGH, rv);
         chk(rv[7:4], 4'h1);
         chk(ntrig - k, 1);
         poll();
         chk(rv, {4'h0, q[$][11:8]});
         rd(`DACR_OFF_AD_LOW, rv);
         chk(rv, q[$][7:0]);
         chk(BUSY_O, 0);
      end
      // Pacer only: software strobe refused, no interrupt path
      cdelay = 8'h04;
      k = ntrig;
      // Unlisted code 011 enables nothing, strobe included
      wr(`DACR_OFF_MODE, 8'h13);
      wr(`DACR_OFF_TRIGGER, 8'($random(seed)));
      wr(`DACR_OFF_MODE, 8'h12);
      wr(`DACR_OFF_TRIGGER, 8'($random(seed)));
      tick(1);
      chk(ntrig, k);
      wait_sig(1);
      t1 = cyc;
      wait_sig(1);
      chk(cyc - t1, 12);
      wait_sig(0);
      tick(1);
      chk({IRQ_FLAG_O, IRQ_O}, 0);
      // Longer period keeps the next completion clear of the checks
      plo = 16'h000a;
      phi = 16'h0005;
      for (i = 0; i < 8; i++) begin
         wr(`DACR_OFF_MODE, {1'b0, i[2:0], 4'h6});
         wait_sig(0);
         chk(IRQ_FLAG_O, 1);
         chk(IRQ_O, irq_exp(i));
         rd(`DACR_OFF_AD_HIGH, rv);
         chk(rv, {4'h0, q[$][11:8]});
         wr(`DACR_OFF_IRQ_CLEAR, 8'($random(seed)));
         tick(1);
         chk({IRQ_FLAG_O, IRQ_O}, 0);
      end
      results();
   end
endmodule
`default_nettype wire
